// File: design/dcaop_pkg.sv
// Shared constants, timing tables and state encoding for the converter output port.
package dcaop_pkg;

  // ==========================================================================
  // Widths and pin sampling layout
  localparam int WORD_BITS     = 16;
  localparam int FRAME_BITS    = 32;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_CONV      = 0;
  localparam int PIN_PAIR      = 1;
  localparam int PIN_BYTE      = 2;
  localparam int PIN_CHAN      = 3;
  localparam int PIN_PORT      = 4;
  localparam int PIN_LOWP      = 5;
  localparam int PIN_EXT       = 6;
  localparam int PIN_DIV       = 7;
  localparam int PIN_ECLK      = 9;
  localparam int PIN_WIDTH     = 10;
  localparam logic [PIN_WIDTH-1:0] PIN_RESET = 10'h001;

  // ==========================================================================
  // Serial clock figures per divider code, in nanoseconds and microseconds
  localparam int SCK_PER_MIN_NS [4] = '{25, 50, 100, 200};
  localparam int SCK_PER_TYP_NS [4] = '{40, 70, 140, 280};
  localparam int SCK_HI_MIN_NS  [4] = '{12, 22, 50, 100};
  localparam int SCK_LO_MIN_NS  [4] = '{7, 21, 49, 99};
  localparam int FIRST_EDGE_NS  [4] = '{3, 17, 17, 17};
  localparam int LAST_EDGE_NS   [4] = '{1, 3, 30, 80};
  localparam int HOLD_MIN_NS    [4] = '{2, 4, 30, 80};
  localparam real BUSY_NORM_US  [4] = '{3.25, 4.25, 6.25, 10.75};
  localparam real BUSY_LOWP_US  [4] = '{3.5, 4.5, 6.5, 11.0};

  function automatic int cyc_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int cyc_dn_us(input real us);
    return $rtoi(us * 1000.0 / real'(CLK_PERIOD_NS));
  endfunction

  // ==========================================================================
  // Cycle counts derived from the figures above
  localparam int SCK_HI_CYC [4] = '{cyc_up(SCK_PER_TYP_NS[0] / 2), cyc_up(SCK_PER_TYP_NS[1] / 2),
                                    cyc_up(SCK_PER_TYP_NS[2] / 2), cyc_up(SCK_PER_TYP_NS[3] / 2)};
  localparam int SCK_LO_CYC [4] = '{SCK_PER_TYP_NS[0] / CLK_PERIOD_NS - SCK_HI_CYC[0],
                                    SCK_PER_TYP_NS[1] / CLK_PERIOD_NS - SCK_HI_CYC[1],
                                    SCK_PER_TYP_NS[2] / CLK_PERIOD_NS - SCK_HI_CYC[2],
                                    SCK_PER_TYP_NS[3] / CLK_PERIOD_NS - SCK_HI_CYC[3]};
  localparam int LEAD_CYC   [4] = '{cyc_up(FIRST_EDGE_NS[0]), cyc_up(FIRST_EDGE_NS[1]),
                                    cyc_up(FIRST_EDGE_NS[2]), cyc_up(FIRST_EDGE_NS[3])};
  localparam int TRAIL_CYC  [4] = '{cyc_up(LAST_EDGE_NS[0]), cyc_up(LAST_EDGE_NS[1]),
                                    cyc_up(LAST_EDGE_NS[2]), cyc_up(LAST_EDGE_NS[3])};

  // ==========================================================================
  // Sequencer states, Gray coded along idle-convert-lead-shift-trail
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_CONVERT = 3'h1,
    ST_LEAD    = 3'h3,
    ST_SHIFT   = 3'h2,
    ST_TRAIL   = 3'h6,
    ST_SLAVE   = 3'h4
  } dcaop_state_type;

endpackage

// File: design/dcaop_sclk_gen.sv
// Shift clock generator with programmable high and low phase lengths.
`timescale 1ns/1ps

module dcaop_sclk_gen (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       run_in,
  input  wire logic [4:0] high_cycles_in,
  input  wire logic [4:0] low_cycles_in,
  output logic            shift_clock_out,
  output logic            rise_out,
  output logic            fall_out
);

  logic [4:0] phase_cnt;

  // A phase ends once it has lasted its programmed count; the caller only
  // drops run_in while the clock is low, so no high phase is ever cut short.
  assign rise_out = run_in && !shift_clock_out && (phase_cnt >= low_cycles_in - 5'h01);
  assign fall_out = run_in && shift_clock_out && (phase_cnt >= high_cycles_in - 5'h01);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_clock_out <= 1'b0;
      phase_cnt       <= 5'h00;
    end else if (!run_in) begin
      shift_clock_out <= 1'b0;
      phase_cnt       <= 5'h00;
    end else if (rise_out || fall_out) begin
      shift_clock_out <= !shift_clock_out;
      phase_cnt       <= 5'h00;
    end else begin
      phase_cnt <= phase_cnt + 5'h01;
    end
  end

endmodule

// File: design/dcaop_top.sv
// Output port and channel selection logic of a two-channel sampling converter.
`timescale 1ns/1ps

// What this block does
// R1 - Pair select low samples first pair, else second.
// R2 - Byte order select swaps parallel result bytes.
// R3 - Parallel: channel B when order low, else A.
// R4 - Serial: order high sends A then B.
// R5 - Master shift clock period meets divider minimum.
// R6 - Shift clock period is the typical divider value.
// R7 - Normal mode busy width stays under maximum.
// R8 - Low power busy width stays under maximum.
// R9 - Shift clock high phase meets divider minimum.
// R10 - Shift clock low phase meets divider minimum.
// R11 - Frame sync leads first clock edge enough.
// R12 - Frame sync holds after last clock edge.
// R13 - Serial data held after its clock edge.
// R14 - Divider used only in master read-after-convert.
// R15 - Port type selects parallel bus or serial port.
// R16 - Low power select gives reduced power mode.
module dcaop_top (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        convert_start_b_in,
  input  wire logic        pair_select_in,
  input  wire logic        byte_order_select_in,
  input  wire logic        channel_order_select_in,
  input  wire logic        port_type_select_in,
  input  wire logic        low_power_select_in,
  input  wire logic        ext_clock_select_in,
  input  wire logic [1:0]  serial_clock_divider_in,
  input  wire logic        ext_shift_clock_in,
  input  wire logic [15:0] result_a_in,
  input  wire logic [15:0] result_b_in,
  input  wire logic        convert_done_in,
  output logic             convert_request_out,
  output logic             pair_select_out,
  output logic             low_power_out,
  output logic             busy_out,
  output logic [15:0]      parallel_data_out,
  output logic [15:0]      parallel_data_oe_out,
  output logic             frame_sync_out,
  output logic             frame_sync_oe_out,
  output logic             shift_clock_out,
  output logic             shift_clock_oe_out,
  output logic             serial_data_out,
  output logic             serial_data_oe_out
);

  // ==========================================================================
  // Pin synchronisers
  logic [dcaop_pkg::PIN_WIDTH-1:0] pin_raw;
  logic [dcaop_pkg::PIN_WIDTH-1:0] pin_meta;
  logic [dcaop_pkg::PIN_WIDTH-1:0] pin_sync;
  logic                            conv_prev;
  logic                            eclk_prev;

  assign pin_raw = {ext_shift_clock_in, serial_clock_divider_in, ext_clock_select_in,
                    low_power_select_in, port_type_select_in, channel_order_select_in,
                    byte_order_select_in, pair_select_in, convert_start_b_in};

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta  <= dcaop_pkg::PIN_RESET;
      pin_sync  <= dcaop_pkg::PIN_RESET;
      conv_prev <= 1'b1;
      eclk_prev <= 1'b0;
    end else begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      conv_prev <= pin_sync[dcaop_pkg::PIN_CONV];
      eclk_prev <= pin_sync[dcaop_pkg::PIN_ECLK];
    end
  end

  // ==========================================================================
  // Decoded modes
  logic                   port_serial;
  logic                   ext_clock;
  logic                   start_edge;
  logic                   eclk_fall;
  logic                   master_rac;
  logic [1:0]             eff_div;
  logic [15:0]            chan_word;
  dcaop_pkg::dcaop_state_type state;
  logic [3:0]             wait_cnt;
  logic [5:0]             bit_cnt;
  logic [31:0]            shift_reg;
  logic                   sck_run;
  logic                   sck_rise;
  logic                   sck_fall;
  logic [4:0]             hi_cycles;
  logic [4:0]             lo_cycles;

  assign port_serial = pin_sync[dcaop_pkg::PIN_PORT];
  assign ext_clock   = pin_sync[dcaop_pkg::PIN_EXT];
  assign start_edge  = conv_prev && !pin_sync[dcaop_pkg::PIN_CONV];
  assign eclk_fall   = eclk_prev && !pin_sync[dcaop_pkg::PIN_ECLK];
  assign chan_word   = pin_sync[dcaop_pkg::PIN_CHAN] ? result_a_in : result_b_in; // [R3]
  assign hi_cycles   = 5'(dcaop_pkg::SCK_HI_CYC[eff_div]); // [R5] [R6] [R9]
  assign lo_cycles   = 5'(dcaop_pkg::SCK_LO_CYC[eff_div]); // [R6] [R10]
  assign sck_run     = (state == dcaop_pkg::ST_SHIFT);

  // Parallel bus floats in serial mode; the divider and mode straps
  // come into the device on their own input pins, not on the bus.
  assign parallel_data_oe_out = {16{!port_serial}}; // [R15]
  assign serial_data_oe_out   = port_serial; // [R15]
  assign frame_sync_oe_out    = port_serial && !ext_clock;
  assign shift_clock_oe_out   = port_serial && !ext_clock;
  assign serial_data_out      = shift_reg[31];

  dcaop_sclk_gen u_sclk_gen (
    .ref_clk_in      (ref_clk_in),
    .rst_b_in        (rst_b_in),
    .run_in          (sck_run),
    .high_cycles_in  (hi_cycles),
    .low_cycles_in   (lo_cycles),
    .shift_clock_out (shift_clock_out),
    .rise_out        (sck_rise),
    .fall_out        (sck_fall)
  );

  // ==========================================================================
  // Conversion and frame sequencer
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state               <= dcaop_pkg::ST_IDLE;
      wait_cnt            <= 4'h0;
      bit_cnt             <= 6'h00;
      convert_request_out <= 1'b0;
      pair_select_out     <= 1'b0;
      master_rac          <= 1'b0;
      eff_div             <= 2'h0;
      busy_out            <= 1'b0;
      frame_sync_out      <= 1'b0;
    end else begin
      convert_request_out <= 1'b0;
      case (state)
        dcaop_pkg::ST_IDLE: begin
          if (start_edge) begin
            convert_request_out <= 1'b1;
            pair_select_out     <= pin_sync[dcaop_pkg::PIN_PAIR]; // [R1]
            master_rac          <= port_serial && !ext_clock;
            // Outside master read-after-convert the divider straps are
            // ignored and the fastest clock setting applies.
            eff_div <= (port_serial && !ext_clock) ?
                       pin_sync[dcaop_pkg::PIN_DIV +: 2] : 2'h0; // [R14]
            busy_out <= 1'b1;
            state    <= dcaop_pkg::ST_CONVERT;
          end
        end
        dcaop_pkg::ST_CONVERT: begin
          if (convert_done_in) begin
            bit_cnt <= 6'h00;
            if (!port_serial) begin
              busy_out <= 1'b0; // [R15]
              state    <= dcaop_pkg::ST_IDLE;
            end else if (ext_clock) begin
              busy_out <= 1'b0;
              state    <= dcaop_pkg::ST_SLAVE;
            end else begin
              frame_sync_out <= 1'b1;
              wait_cnt       <= 4'(dcaop_pkg::LEAD_CYC[eff_div] - 1); // [R11]
              state          <= dcaop_pkg::ST_LEAD;
            end
          end
        end
        dcaop_pkg::ST_LEAD: begin
          if (wait_cnt == 4'h0) begin
            state <= dcaop_pkg::ST_SHIFT; // [R11]
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        dcaop_pkg::ST_SHIFT: begin
          if (sck_rise) begin
            bit_cnt <= bit_cnt + 6'h01;
          end
          if (sck_fall && bit_cnt == 6'(dcaop_pkg::FRAME_BITS)) begin
            wait_cnt <= 4'(dcaop_pkg::TRAIL_CYC[eff_div] - 1); // [R12]
            state    <= dcaop_pkg::ST_TRAIL;
          end
        end
        dcaop_pkg::ST_TRAIL: begin
          if (wait_cnt == 4'h0) begin
            frame_sync_out <= 1'b0; // [R12]
            busy_out       <= 1'b0; // [R7] [R8]
            state          <= dcaop_pkg::ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        dcaop_pkg::ST_SLAVE: begin
          if (eclk_fall) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == 6'(dcaop_pkg::FRAME_BITS - 1)) begin
              state <= dcaop_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= dcaop_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      parallel_data_out <= 16'h0000;
      shift_reg         <= 32'h0000_0000;
      low_power_out     <= 1'b0;
    end else begin
      low_power_out <= pin_sync[dcaop_pkg::PIN_LOWP]; // [R16]
      if (state == dcaop_pkg::ST_CONVERT && convert_done_in) begin
        parallel_data_out <= pin_sync[dcaop_pkg::PIN_BYTE] ?
                             {chan_word[7:0], chan_word[15:8]} : chan_word; // [R2]
        shift_reg <= pin_sync[dcaop_pkg::PIN_CHAN] ?
                     {result_a_in, result_b_in} : {result_b_in, result_a_in}; // [R4]
      end else if ((sck_fall && bit_cnt != 6'(dcaop_pkg::FRAME_BITS)) ||
                   (state == dcaop_pkg::ST_SLAVE && eclk_fall)) begin
        // Data moves on the falling edge, a whole high phase after the
        // host's rising sampling edge, which covers the hold time.
        shift_reg <= {shift_reg[30:0], 1'b0}; // [R13]
      end
    end
  end

  // ==========================================================================
  // Checks
  logic        sck_prev;
  logic [4:0]  ph_len;
  logic [4:0]  hi_prev;
  logic [10:0] busy_len;
  logic        lowp_busy;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_prev  <= 1'b0;
      ph_len    <= 5'h00;
      hi_prev   <= 5'h00;
      busy_len  <= 11'h000;
      lowp_busy <= 1'b0;
    end else begin
      sck_prev <= shift_clock_out;
      if (shift_clock_out != sck_prev) begin
        ph_len <= 5'h01;
        if (!shift_clock_out) begin
          hi_prev <= ph_len;
        end
      end else if (ph_len != 5'h1F) begin
        ph_len <= ph_len + 5'h01;
      end
      busy_len <= busy_out ? busy_len + 11'h001 : 11'h000;
      if (start_edge && state == dcaop_pkg::ST_IDLE) begin
        lowp_busy <= pin_sync[dcaop_pkg::PIN_LOWP];
      end
    end
  end

  sequence lead_quiet_s;
    !shift_clock_out [*2];
  endsequence

  sequence conv_load_s;
    state == dcaop_pkg::ST_CONVERT && convert_done_in;
  endsequence

  pair_latch_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R1]
    convert_request_out |-> pair_select_out == $past(pin_sync[dcaop_pkg::PIN_PAIR]))
    else $error("Sampled pair does not follow pair select.");

  byte_order_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R2]
    conv_load_s |=> parallel_data_out[7:0] == ($past(pin_sync[dcaop_pkg::PIN_BYTE]) ?
                    $past(chan_word[15:8]) : $past(chan_word[7:0])))
    else $error("Low byte lane holds the wrong result byte.");

  par_channel_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R3]
    conv_load_s and !pin_sync[dcaop_pkg::PIN_BYTE] |=> parallel_data_out ==
      ($past(pin_sync[dcaop_pkg::PIN_CHAN]) ? $past(result_a_in) : $past(result_b_in)))
    else $error("Parallel word comes from the wrong channel.");

  ser_order_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R4]
    conv_load_s |=> shift_reg[31:16] ==
      ($past(pin_sync[dcaop_pkg::PIN_CHAN]) ? $past(result_a_in) : $past(result_b_in)))
    else $error("Serial frame starts with the wrong channel.");

  sck_period_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R5]
    $rose(shift_clock_out) && hi_prev != 5'h00 |->
      32'(hi_prev) + 32'(ph_len) >= dcaop_pkg::cyc_up(dcaop_pkg::SCK_PER_MIN_NS[eff_div]))
    else $error("Shift clock period below its minimum.");

  sck_high_typ_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R6]
    $fell(shift_clock_out) |-> ph_len == hi_cycles)
    else $error("Shift clock high phase differs from its setting.");

  busy_norm_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R7]
    $fell(busy_out) && master_rac && !lowp_busy |->
      32'(busy_len) <= dcaop_pkg::cyc_dn_us(dcaop_pkg::BUSY_NORM_US[eff_div]))
    else $error("Busy too long in normal mode.");

  busy_lowp_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R8]
    $fell(busy_out) && master_rac && lowp_busy |->
      32'(busy_len) <= dcaop_pkg::cyc_dn_us(dcaop_pkg::BUSY_LOWP_US[eff_div]))
    else $error("Busy too long in low power mode.");

  sck_high_min_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R9]
    $fell(shift_clock_out) |->
      32'(ph_len) >= dcaop_pkg::cyc_up(dcaop_pkg::SCK_HI_MIN_NS[eff_div]))
    else $error("Shift clock high phase too short.");

  sck_low_min_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R10]
    $rose(shift_clock_out) |->
      32'(ph_len) >= dcaop_pkg::cyc_up(dcaop_pkg::SCK_LO_MIN_NS[eff_div]))
    else $error("Shift clock low phase too short.");

  sync_lead_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R11]
    $rose(frame_sync_out) && eff_div != 2'h0 |-> lead_quiet_s)
    else $error("Shift clock edge too soon after frame sync.");

  sync_trail_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R12]
    $fell(frame_sync_out) |-> 32'(ph_len) >= dcaop_pkg::TRAIL_CYC[eff_div])
    else $error("Frame sync dropped too soon after last edge.");

  data_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R13]
    $changed(serial_data_out) && master_rac && state == dcaop_pkg::ST_SHIFT |->
      $fell(shift_clock_out) &&
      32'(ph_len) >= dcaop_pkg::cyc_up(dcaop_pkg::HOLD_MIN_NS[eff_div]))
    else $error("Serial data changed inside its hold window.");

  div_ignore_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R14]
    state != dcaop_pkg::ST_IDLE && !master_rac |-> eff_div == 2'h0)
    else $error("Divider applied outside master read-after-convert.");

  port_float_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R15]
    state == dcaop_pkg::ST_SHIFT |-> parallel_data_oe_out == 16'h0000 && serial_data_oe_out)
    else $error("Parallel bus driven during a serial frame.");

  low_power_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [R16]
    $rose(pin_sync[dcaop_pkg::PIN_LOWP]) |=> low_power_out)
    else $error("Low power request not passed to the core.");

endmodule

// File: dv/dcaop_host_model.sv
// Host side model: reads serial frames, measures shift clock timing, makes a slave clock.
`timescale 1ns/1ps

module dcaop_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        frame_sync_in,
  input  wire logic        shift_clock_in,
  input  wire logic        serial_data_in,
  input  wire logic        slave_go_in,
  output logic             ext_clock_out,
  output logic [31:0]      word_out,
  output logic             word_valid_out,
  output logic [31:0]      slave_word_out,
  output logic             slave_valid_out,
  output logic [7:0]       hi_min_out,
  output logic [7:0]       lo_min_out,
  output logic [7:0]       lead_out,
  output logic [7:0]       trail_out
);
  logic        prev_sck;
  logic        prev_fs;
  logic [7:0]  run;
  logic [5:0]  bits;
  logic [31:0] sh;

  // ==========================================================================
  // Master frames: run counts reference cycles since the last edge of either line.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_sck       <= 1'b0;
      prev_fs        <= 1'b0;
      run            <= 8'h00;
      bits           <= 6'h00;
      sh             <= 32'h0000_0000;
      word_out       <= 32'h0000_0000;
      word_valid_out <= 1'b0;
      hi_min_out     <= 8'hFF;
      lo_min_out     <= 8'hFF;
      lead_out       <= 8'h00;
      trail_out      <= 8'h00;
    end else begin
      prev_sck       <= shift_clock_in;
      prev_fs        <= frame_sync_in;
      word_valid_out <= prev_fs && !frame_sync_in;
      run <= (frame_sync_in != prev_fs || shift_clock_in != prev_sck) ? 8'h01 : run + 8'h01;
      if (frame_sync_in && !prev_fs) begin
        bits       <= 6'h00;
        hi_min_out <= 8'hFF;
        lo_min_out <= 8'hFF;
      end
      if (frame_sync_in && shift_clock_in && !prev_sck) begin
        sh   <= {sh[30:0], serial_data_in};
        bits <= bits + 6'h01;
        if (bits == 6'h00) lead_out <= run;
        else if (run < lo_min_out) lo_min_out <= run;
      end
      if (!shift_clock_in && prev_sck && run < hi_min_out) hi_min_out <= run;
      if (prev_fs && !frame_sync_in) begin
        word_out  <= sh;
        trail_out <= run;
      end
    end
  end

  // ==========================================================================
  // Slave frames: the clock stands low outside frames, 80 ns period, off the reference phase.
  initial begin
    ext_clock_out   = 1'b0;
    slave_valid_out = 1'b0;
    slave_word_out  = 32'h0000_0000;
    forever begin
      @(posedge slave_go_in);
      #3;
      repeat (32) begin
        slave_word_out = {slave_word_out[30:0], serial_data_in};
        ext_clock_out  = 1'b1;
        #40;
        ext_clock_out = 1'b0;
        #40;
      end
      slave_valid_out = 1'b1;
      @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      slave_valid_out = 1'b0;
    end
  end
endmodule

// File: dv/tb_top.sv
// Self-checking testbench for the converter output port.
`timescale 1ns/1ps

module tb_top;
  logic ref_clk_in, rst_b_in, convert_start_b_in, pair_select_in, byte_order_select_in;
  logic channel_order_select_in, port_type_select_in, low_power_select_in, ext_clock_select_in;
  logic [1:0]  serial_clock_divider_in;
  logic        ext_shift_clock_in, convert_done_in, slave_go, word_valid, slave_valid;
  logic [15:0] result_a_in, result_b_in, parallel_data_out, parallel_data_oe_out;
  logic convert_request_out, pair_select_out, low_power_out, busy_out, frame_sync_out;
  logic frame_sync_oe_out, shift_clock_out, shift_clock_oe_out, serial_data_out;
  logic        serial_data_oe_out;
  logic        prev_busy = 1'b0;
  logic [31:0] word, slave_word;
  logic [7:0]  hi_min, lo_min, lead, trail;
  logic [31:0] exp_q[$];
  int          errors = 0;
  int          tests_run = 0;

  dcaop_top u_dut (.ref_clk_in, .rst_b_in, .convert_start_b_in, .pair_select_in,
    .byte_order_select_in, .channel_order_select_in, .port_type_select_in,
    .low_power_select_in, .ext_clock_select_in, .serial_clock_divider_in, .ext_shift_clock_in,
    .result_a_in, .result_b_in, .convert_done_in, .convert_request_out, .pair_select_out,
    .low_power_out, .busy_out, .parallel_data_out, .parallel_data_oe_out, .frame_sync_out,
    .frame_sync_oe_out, .shift_clock_out, .shift_clock_oe_out, .serial_data_out,
    .serial_data_oe_out);

  dcaop_host_model u_host (.ref_clk_in, .rst_b_in, .frame_sync_in(frame_sync_out),
    .shift_clock_in(shift_clock_out), .serial_data_in(serial_data_out), .slave_go_in(slave_go),
    .ext_clock_out(ext_shift_clock_in), .word_out(word), .word_valid_out(word_valid),
    .slave_word_out(slave_word), .slave_valid_out(slave_valid), .hi_min_out(hi_min),
    .lo_min_out(lo_min), .lead_out(lead), .trail_out(trail));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic compare(input string name, input logic [31:0] seen);
    if (exp_q.size() == 0) check({name, "_unexpected"}, 32'h1, 32'h0);
    else check(name, seen, exp_q.pop_front());
  endtask

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // One conversion; sel holds channel order, byte order and pair select from high to low.
  task automatic convert(input logic [2:0] sel, input logic port, input logic ext,
                         input logic [1:0] div);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] w;
    int          n;
    int          lim;
    a = 16'($urandom);
    b = 16'($urandom);
    w = sel[2] ? a : b;
    @(negedge ref_clk_in);
    {channel_order_select_in, byte_order_select_in, pair_select_in} = sel;
    port_type_select_in = port;
    ext_clock_select_in = ext;
    serial_clock_divider_in = div;
    low_power_select_in = 1'($urandom);
    if (!port) exp_q.push_back({16'h0000, sel[1] ? {w[7:0], w[15:8]} : w});
    else exp_q.push_back(sel[2] ? {a, b} : {b, a});
    convert_start_b_in = 1'b0;
    n = 0;
    while (convert_request_out !== 1'b1 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("request", n < 20, 32'h1);
    check("pair", pair_select_out, sel[0]);
    check("low_power", low_power_out, low_power_select_in);
    check("par_oe", parallel_data_oe_out, port ? 16'h0000 : 16'hFFFF);
    check("ser_oe", {frame_sync_oe_out, shift_clock_oe_out, serial_data_oe_out},
          {port & !ext, port & !ext, port});
    convert_start_b_in = 1'b1;
    repeat (100) @(negedge ref_clk_in);
    result_a_in = a;
    result_b_in = b;
    convert_done_in = 1'b1;
    @(negedge ref_clk_in);
    convert_done_in = 1'b0;
    n = 101;
    while (busy_out === 1'b1 && n < 1500) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (ext) begin
      slave_go = 1'b1;
      @(negedge ref_clk_in);
      slave_go = 1'b0;
      wait (slave_valid === 1'b1);
    end
    repeat (5) @(negedge ref_clk_in);
    if (port && !ext) begin
      lim = low_power_select_in ? $rtoi(dcaop_pkg::BUSY_LOWP_US[div] * 100.0)
                                : $rtoi(dcaop_pkg::BUSY_NORM_US[div] * 100.0);
      if (low_power_select_in) check("busy_max", n <= lim, 32'h1);
      else check("busy_max", n <= lim, 32'h1);
      check("period_typ", (hi_min + lo_min) * 10, dcaop_pkg::SCK_PER_TYP_NS[div]);
      check("period_min", (hi_min + lo_min) * 10 >= dcaop_pkg::SCK_PER_MIN_NS[div], 1);
      check("high", hi_min * 10 >= dcaop_pkg::SCK_HI_MIN_NS[div], 32'h1);
      check("low", lo_min * 10 >= dcaop_pkg::SCK_LO_MIN_NS[div], 32'h1);
      check("lead", lead * 10 >= dcaop_pkg::FIRST_EDGE_NS[div], 32'h1);
      check("trail", trail * 10 >= dcaop_pkg::LAST_EDGE_NS[div], 32'h1);
      check("hold", hi_min * 10 >= dcaop_pkg::HOLD_MIN_NS[div], 32'h1);
    end
  endtask

  // ==========================================================================
  // Result watcher: takes the oldest expectation whenever a word shows at the outputs.
  always @(negedge ref_clk_in) begin
    if (!busy_out && prev_busy && !port_type_select_in)
      compare("parallel", {16'h0000, parallel_data_out});
    if (word_valid) compare("master_frame", word);
    if (slave_valid) compare("slave_frame", slave_word);
    prev_busy = busy_out;
  end

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // The longest run is about 3800 cycles, so 30000 leaves ample margin.
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    errors++;
    give_verdict();
  end

  initial begin
    {rst_b_in, pair_select_in, byte_order_select_in, channel_order_select_in} = 4'h0;
    {port_type_select_in, low_power_select_in, ext_clock_select_in, convert_done_in} = 4'h0;
    {convert_start_b_in, slave_go, serial_clock_divider_in} = 4'h8;
    {result_a_in, result_b_in} = 32'h0000_0000;
    void'($urandom(40));
    repeat (16) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    for (int i = 0; i < 8; i++) convert(3'(i), 1'b0, 1'b0, 2'($urandom));
    for (int i = 0; i < 4; i++) convert({i[0], 2'($urandom)}, 1'b1, 1'b0, 2'(i));
    for (int i = 0; i < 2; i++) convert({i[0], 2'($urandom)}, 1'b1, 1'b1, 2'($urandom));
    give_verdict();
  end
endmodule
